// ---- src/ris_pkg.sv ----
// Constants and types shared by the reset initialization sequencer
// Summary of operation
// [R1] External reset input must stay low 32 ticks
// [R2] Host mode power-on reset held 32 clocks
// [R3] Agent mode power-on reset held 32 ticks
// [R4] Driven hard and soft resets held 512 ticks
// [R5] Soft release at least 16 ticks after hard
// [R6] Configuration valid 4 clocks before power-on release
// [R7] Configuration pins off during hard reset, on later
// [R8] Sample three-bit source and divide bit
// [R9] Reset lines are open drain, low only
// [R10] Allow 7680 to 122880 cycles for DLL lock
// [R11] Primary clock source follows host or agent mode
// [R12] Host mode tick rate follows divide bit
// [R13] Hold internal reset until PLL and DLL lock; code also releases it after a lock wait timeout without lock
package ris_pkg;

    // Clock rate and lock timing
    localparam int unsigned CLK_MHZ        = 50;
    localparam int unsigned PLL_LOCK_US    = 100;
    localparam int unsigned PLL_LOCK_CYCLES = PLL_LOCK_US * CLK_MHZ;
    localparam int unsigned DLL_MIN_CYCLES = 7680;
    localparam int unsigned DLL_MAX_CYCLES = 122880;

    // Sequence counts in sync clock ticks
    localparam logic [16:0] HRST_TICKS     = 17'h00200;
    localparam logic [16:0] SOFT_LAG_TICKS = 17'h00010;
    localparam logic [16:0] CFG_ON_TICKS   = 17'h00001;
    localparam logic [5:0]  EXT_ASSERT_TICKS = 6'h20;

    // Reset values
    localparam logic [2:0]  CFG_SOURCE_RST = 3'h0;
    localparam logic        CFG_DIV_RST    = 1'h0;
    localparam logic        HOST_MODE_RST  = 1'h1;

    // Synchroniser layout
    localparam int unsigned SYNC_W    = 10;
    localparam int unsigned SY_POR    = 0;
    localparam int unsigned SY_HRST   = 1;
    localparam int unsigned SY_SRST   = 2;
    localparam int unsigned SY_HOST   = 3;
    localparam int unsigned SY_CFG_LO = 4;
    localparam int unsigned SY_DIV    = 7;
    localparam int unsigned SY_PLL    = 8;
    localparam int unsigned SY_DLL    = 9;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_POR,
        ST_LOCK,
        ST_HRST,
        ST_SRST,
        ST_SOFT,
        ST_RUN
    } ris_state_t;

endpackage : ris_pkg

// ---- src/ris_sync.sv ----
// Two-flop synchroniser bank for pin inputs
module ris_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    // Asynchronous and synchronised data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // First stage read only by the second
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : ris_sync

// ---- src/ris_reset_init_sequencer.sv ----
// Reset initialization sequencer: lock wait and ordered reset release
module ris_reset_init_sequencer
    import ris_pkg::*;
#(
    parameter int unsigned PLL_LOCK_CYC = ris_pkg::PLL_LOCK_CYCLES,
    parameter int unsigned DLL_MIN_CYC  = ris_pkg::DLL_MIN_CYCLES,
    parameter int unsigned DLL_MAX_CYC  = ris_pkg::DLL_MAX_CYCLES
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    // Reset pins
    input  wire logic       power_on_reset_n_in,
    input  wire logic       hard_reset_n_in,
    input  wire logic       soft_reset_n_in,
    output logic            hard_reset_n_out,
    output logic            hard_reset_n_oe_out,
    output logic            soft_reset_n_out,
    output logic            soft_reset_n_oe_out,
    // Power-on configuration pins
    input  wire logic       host_mode_in,
    input  wire logic [2:0] cfg_reset_source_in,
    input  wire logic       input_clock_divide_select_in,
    output logic [2:0]      cfg_reset_source_out,
    output logic            input_clock_divide_select_out,
    output logic            cfg_oe_out,
    // Lock indications
    input  wire logic       pll_lock_in,
    input  wire logic       dll_lock_in,
    // Internal controls and status
    output logic            core_reset_n_out,
    output logic            clk_sel_host_out,
    output logic            sync_tick_out,
    output logic            lock_timeout_out
);

    import ris_pkg::*;

    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_s;
    logic              por_s;
    logic              por_d_reg;
    logic              por_rise;
    logic              host_reg;
    logic              div_reg;
    logic [2:0]        cfg_reg;
    logic              half_reg;
    logic              tick;
    ris_state_t        state_reg;
    ris_state_t        state_next;
    logic [16:0]       cnt_reg;
    logic [16:0]       cnt_next;
    logic [5:0]        ext_cnt_reg;
    logic              ext_low;
    logic              lock_ok;
    logic              lock_late;
    logic              hard_oe_next;
    logic              soft_oe_next;

    // Pin inputs through two flops
    assign pins_async = {dll_lock_in, pll_lock_in,
                         input_clock_divide_select_in, cfg_reset_source_in,
                         host_mode_in, soft_reset_n_in, hard_reset_n_in,
                         power_on_reset_n_in};

    ris_sync #(.WIDTH(SYNC_W)) u_sync (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .async_in (pins_async),
        .sync_out (pins_s)
    );

    assign por_s    = pins_s[SY_POR];
    assign por_rise = por_s && !por_d_reg;
    assign ext_low  = !pins_s[SY_HRST] || !pins_s[SY_SRST];

    // Power-on release edge detect
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            por_d_reg <= 1'b0;
        end else begin
            por_d_reg <= por_s;
        end
    end

    // Configuration sampled at power-on release
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_reg  <= CFG_SOURCE_RST;
            div_reg  <= CFG_DIV_RST;
            host_reg <= HOST_MODE_RST;
        end else if (por_rise) begin
            cfg_reg  <= pins_s[SY_CFG_LO +: 3]; // R8 R6
            div_reg  <= pins_s[SY_DIV];       // R8
            host_reg <= pins_s[SY_HOST];
        end
    end

    // Sync tick: halved in host mode when divide bit set
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            half_reg <= 1'b0;
        end else begin
            half_reg <= !half_reg;
        end
    end

    assign tick = !(host_reg && div_reg) || half_reg; // R12

    // Lock wait exits
    assign lock_ok   = pins_s[SY_PLL] && pins_s[SY_DLL] &&
                       (cnt_reg >= 17'(DLL_MIN_CYC - 1));         // R10 R13
    assign lock_late = (cnt_reg >= 17'(DLL_MAX_CYC - 1)) ||
                       (!pins_s[SY_PLL] &&
                        cnt_reg >= 17'(PLL_LOCK_CYC - 1));        // R10

    // Next state and counter
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
            ST_POR: begin
                if (por_s) begin
                    state_next = ST_LOCK;
                end
            end
            ST_LOCK: begin
                cnt_next = cnt_reg + 17'h00001;
                if (lock_ok || lock_late) begin                  // R13
                    state_next = ST_HRST;
                    cnt_next   = '0;
                end
            end
            ST_HRST: begin
                if (tick) begin
                    cnt_next = cnt_reg + 17'h00001;
                    if (cnt_reg == HRST_TICKS - 17'h00001) begin // R4
                        state_next = ST_SRST;
                        cnt_next   = '0;
                    end
                end
            end
            ST_SRST: begin
                if (tick) begin
                    cnt_next = cnt_reg + 17'h00001;
                    if (cnt_reg == SOFT_LAG_TICKS - 17'h00001) begin // R5
                        state_next = ST_RUN;
                        cnt_next   = '0;
                    end
                end
            end
            ST_SOFT: begin
                if (tick) begin
                    cnt_next = cnt_reg + 17'h00001;
                    if (cnt_reg == HRST_TICKS - 17'h00001) begin // R4
                        state_next = ST_RUN;
                        cnt_next   = '0;
                    end
                end
            end
            ST_RUN: begin
                if (tick && ext_low &&
                    ext_cnt_reg == EXT_ASSERT_TICKS - 6'h01) begin // R1
                    state_next = pins_s[SY_HRST] ? ST_SOFT : ST_HRST;
                end
            end
        endcase
        if (!por_s) begin
            state_next = ST_POR;
            cnt_next   = '0;
        end
    end

    // State and counter registers
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= ST_POR;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Filter on externally asserted reset inputs
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ext_cnt_reg <= '0;
        end else if (state_reg != ST_RUN || !ext_low) begin
            ext_cnt_reg <= '0;
        end else if (tick && ext_cnt_reg != EXT_ASSERT_TICKS - 6'h01) begin
            ext_cnt_reg <= ext_cnt_reg + 6'h01;                  // R1
        end
    end

    assign hard_oe_next = state_next inside {ST_POR, ST_LOCK, ST_HRST};
    assign soft_oe_next = hard_oe_next || state_next inside {ST_SRST, ST_SOFT};

    // Registered pin drivers, low only
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hard_reset_n_oe_out <= 1'b1;
            soft_reset_n_oe_out <= 1'b1;
            hard_reset_n_out    <= 1'b0;
            soft_reset_n_out    <= 1'b0;
        end else begin
            hard_reset_n_oe_out <= hard_oe_next;                 // R9
            soft_reset_n_oe_out <= soft_oe_next;                 // R9
            hard_reset_n_out    <= 1'b0;                         // R9
            soft_reset_n_out    <= 1'b0;                         // R9
        end
    end

    // Configuration pin drive after hard release
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_oe_out                    <= 1'b0;
            cfg_reset_source_out          <= CFG_SOURCE_RST;
            input_clock_divide_select_out <= CFG_DIV_RST;
        end else begin
            cfg_oe_out <= !hard_oe_next && pins_s[SY_HRST] &&
                          (state_next != ST_SRST ||
                           cnt_next >= CFG_ON_TICKS);              // R7
            cfg_reset_source_out          <= cfg_reg;
            input_clock_divide_select_out <= div_reg;
        end
    end

    // Internal reset, clock select and status
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            core_reset_n_out <= 1'b0;
            clk_sel_host_out <= HOST_MODE_RST;
            sync_tick_out    <= 1'b0;
            lock_timeout_out <= 1'b0;
        end else begin
            core_reset_n_out <= !hard_oe_next;                   // R13
            clk_sel_host_out <= host_reg;                        // R11
            sync_tick_out    <= tick;
            if (state_reg == ST_POR) begin
                lock_timeout_out <= 1'b0;
            end else if (state_reg == ST_LOCK && !lock_ok && lock_late) begin
                lock_timeout_out <= 1'b1;
            end
        end
    end

    // Checks on sequencing, all on the one clock
    default clocking cb_chk @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_pin_low_only: assert property (!hard_reset_n_out && // R9
        !soft_reset_n_out)
        else $error("reset pin driven high");
    a_hard_hold_min: assert property ($fell(hard_reset_n_oe_out) |-> // R4
        $past(state_reg) == ST_HRST &&
        $past(cnt_reg) == HRST_TICKS - 17'h00001)
        else $error("hard reset released early");
    a_soft_lag_min: assert property ($fell(soft_reset_n_oe_out) && // R5
        $past(state_reg) == ST_SRST |->
        $past(cnt_reg) == SOFT_LAG_TICKS - 17'h00001)
        else $error("soft reset released too soon after hard");
    a_cfg_off_hard: assert property (hard_reset_n_oe_out || // R7
        !$past(pins_s[SY_HRST]) |-> !cfg_oe_out)
        else $error("config pins driven during hard reset");
    a_cfg_on_delay: assert property ($rose(cfg_oe_out) |-> // R7
        !$past(hard_reset_n_oe_out) && !$past(hard_reset_n_oe_out, 2))
        else $error("config pins driven right after hard release");
    a_cfg_sample: assert property (por_rise |=> ##1 // R8
        cfg_reset_source_out == $past(pins_s[SY_CFG_LO +: 3], 2) &&
        input_clock_divide_select_out == $past(pins_s[SY_DIV], 2))
        else $error("configuration not sampled at power-on release");
    a_lock_wait_ok: assert property (state_reg == ST_LOCK && // R10 R13
        state_next == ST_HRST && !(pins_s[SY_PLL] && pins_s[SY_DLL]) |=>
        lock_timeout_out)
        else $error("lock wait left without lock and no timeout flag");
    a_dll_min_wait: assert property (!lock_late && // R10
        state_reg == ST_LOCK && state_next == ST_HRST |->
        cnt_reg >= 17'(DLL_MIN_CYC - 1))
        else $error("lock wait shorter than minimum");
    a_tick_halved: assert property (host_reg && div_reg && tick && // R12
        !por_rise |=> !tick)
        else $error("tick not halved in divided host mode");
    a_clk_select: assert property (por_rise |=> ##1 // R11
        clk_sel_host_out == $past(pins_s[SY_HOST], 2))
        else $error("clock select does not follow sampled mode");
    a_ext_filter: assert property (state_reg == ST_RUN && // R1
        state_next inside {ST_HRST, ST_SOFT} |->
        ext_cnt_reg == EXT_ASSERT_TICKS - 6'h01)
        else $error("external reset accepted too short");
    c_full_seq: cover property (state_reg == ST_SRST ##1 state_reg == ST_RUN);
    c_lock_late: cover property ($rose(lock_timeout_out));
    c_ext_soft: cover property (state_reg == ST_RUN ##1 state_reg == ST_SOFT);
    c_ext_hard: cover property (state_reg == ST_RUN ##1 state_reg == ST_HRST);

endmodule : ris_reset_init_sequencer

// ---- sim/ris_board_model.sv ----
// Board reset supervisor and strapping model
module ris_board_model (
    // Clock
    input  wire logic       clk_in,
    // Device open-drain enables
    input  wire logic       hard_oe_in,
    input  wire logic       soft_oe_in,
    // Pins toward the device
    output logic            por_n_out,
    output logic            host_out,
    output logic [2:0]      src_out,
    output logic            div_out,
    output logic            pll_out,
    output logic            dll_out,
    output logic            hard_out,
    output logic            soft_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic hpull = 1'b0;
    logic spull = 1'b0;
    int   pll_d = 0;
    int   dll_d = 0;
    int   cnt   = 0;

    // Pulled-up lines, low while either side pulls
    assign hard_out = (hard_oe_in || hpull) ? 1'b0 : 1'b1;
    assign soft_out = (soft_oe_in || spull) ? 1'b0 : 1'b1;

    // Lock indications some cycles after power-on release
    always @(posedge clk_in) begin
        cnt <= por_n_out ? cnt + 1 : 0;
    end
    assign pll_out = por_n_out && (cnt >= pll_d);
    assign dll_out = por_n_out && (cnt >= dll_d);

    initial begin
        por_n_out = 1'b0;
        host_out  = 1'b1;
        src_out   = 3'h0;
        div_out   = 1'b0;
    end

    // Power-on with straps stable well before release
    task automatic power_up(input logic h, input logic [2:0] s,
                            input logic d, input int pd, input int dd);
        @(posedge clk_in);
        #1;
        pll_d = pd;
        dll_d = dd;
        por_n_out = 1'b0;
        host_out = h;
        src_out = s;
        div_out = d;
        repeat (40) @(posedge clk_in);
        #1;
        por_n_out = 1'b1;
    endtask : power_up

    // Straps let go once hard reset is over
    task automatic release_straps;
        host_out = ~host_out;
        src_out = ~src_out;
        div_out = ~div_out;
    endtask : release_straps

    // Pull reset lines low for a number of clocks
    task automatic pull(input logic h, input logic s, input int n);
        hpull = h;
        spull = s;
        repeat (n) @(posedge clk_in);
        #1;
        hpull = 1'b0;
        spull = 1'b0;
    endtask : pull
endmodule : ris_board_model

// ---- sim/testbench.sv ----
// Self-checking testbench for the reset initialization sequencer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_in;
    logic       rstn_in;
    logic       por_n, host, div, pll, dll, hard_w, soft_w;
    logic [2:0] src, src_w;
    logic       div_w;
    logic       hard_out, hard_oe, soft_out, soft_oe;
    logic [2:0] src_out;
    logic       div_out, cfg_oe, core_n, clk_sel, tick, tmo;
    int         err_count   = 0;
    int         check_count = 0;

    // Shared config pins: device or straps
    assign src_w = cfg_oe ? src_out : src;
    assign div_w = cfg_oe ? div_out : div;

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    ris_board_model board (
        .clk_in(clk_in), .hard_oe_in(hard_oe), .soft_oe_in(soft_oe),
        .por_n_out(por_n), .host_out(host), .src_out(src),
        .div_out(div), .pll_out(pll), .dll_out(dll),
        .hard_out(hard_w), .soft_out(soft_w));

    ris_reset_init_sequencer #(
        .PLL_LOCK_CYC(20), .DLL_MIN_CYC(40), .DLL_MAX_CYC(200)
    ) uut (
        .clk_in(clk_in), .rstn_in(rstn_in),
        .power_on_reset_n_in(por_n), .hard_reset_n_in(hard_w),
        .soft_reset_n_in(soft_w), .hard_reset_n_out(hard_out),
        .hard_reset_n_oe_out(hard_oe), .soft_reset_n_out(soft_out),
        .soft_reset_n_oe_out(soft_oe), .host_mode_in(host),
        .cfg_reset_source_in(src_w),
        .input_clock_divide_select_in(div_w),
        .cfg_reset_source_out(src_out),
        .input_clock_divide_select_out(div_out), .cfg_oe_out(cfg_oe),
        .pll_lock_in(pll), .dll_lock_in(dll), .core_reset_n_out(core_n),
        .clk_sel_host_out(clk_sel), .sync_tick_out(tick),
        .lock_timeout_out(tmo));

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask : check

    // Clocks until an output reaches a level, bounded
    task automatic wait_lvl(input int sel, input logic lvl, output int n);
        logic v;
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
            case (sel)
                0: v = hard_oe;
                1: v = soft_oe;
                2: v = cfg_oe;
                default: v = core_n;
            endcase
        end while (v !== lvl && n < 5000);
    endtask : wait_lvl

    // Reset lines never driven high
    always @(negedge clk_in) begin
        if (rstn_in) check("open drain", 0, {hard_out, soft_out});
    end

    // Power-on flow: sampling, lock wait, ordered release
    task automatic t_flow(input logic h, input logic [2:0] s,
                          input logic d);
        int n, m, k;
        logic t0;
        k = (h && d) ? 2 : 1;
        board.power_up(h, s, d, 5, 10);
        repeat (4) @(posedge clk_in);
        #1;
        check("source", s, src_out);
        check("divide", d, div_out);
        check("clk sel", h, clk_sel);
        check("core", 0, core_n);
        wait_lvl(0, 1'b0, n);
        check("hard hold", 1, n >= 36 + 512 * k && n <= 60 + 512 * k);
        check("cfg off", 0, cfg_oe);
        check("core", 1, core_n);
        check("timeout", 0, tmo);
        wait_lvl(2, 1'b1, n);
        check("cfg on", 1, n >= 1 && n <= 2 * k + 1);
        wait_lvl(1, 1'b0, m);
        check("soft lag", 1, n + m >= 16 * k && n + m <= 16 * k + 3);
        board.release_straps();
        repeat (3) @(posedge clk_in);
        #1;
        check("source kept", s, src_out);
        t0 = tick;
        @(posedge clk_in);
        #1;
        check("tick", (k == 2) ? {t0, !t0} : 2'h3, {t0, tick});
    endtask : t_flow

    // Reset requested from outside on a pin
    task automatic t_ext(input logic h);
        int n;
        board.pull(h, !h, 20);
        check("cfg while line low", h ? 1'b0 : 1'b1, cfg_oe);
        repeat (4) @(posedge clk_in);
        #1;
        check("short pulse", 0, {hard_oe, soft_oe});
        fork
            board.pull(h, !h, 40);
        join_none
        wait_lvl(h ? 0 : 1, 1'b1, n);
        check("ext delay", 1, n >= 32 && n <= 37);
        check("hard oe", h, hard_oe);
        check("cfg off", 0, h ? cfg_oe : 1'b0);
        wait_lvl(h ? 0 : 1, 1'b0, n);
        check("ext hold", 1, n >= 511 && n <= 514);
        if (h) begin
            wait_lvl(1, 1'b0, n);
            check("ext lag", 1, n >= 16 && n <= 19);
        end
    endtask : t_ext

    // DLL never locks: flow goes on after the longest wait
    task automatic t_timeout;
        int n;
        board.power_up(1'b1, 3'h2, 1'b0, 5, 100000);
        wait_lvl(3, 1'b1, n);
        check("timeout", 1, tmo);
        check("lock wait", 1, n >= 702 && n <= 735);
        wait_lvl(1, 1'b0, n);
        check("timeout lag", 1, n >= 16 && n <= 19);
    endtask : t_timeout

    task automatic test_done;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    // Watchdog sized well above the whole sequence
    initial begin
        repeat (60000) @(posedge clk_in);
        err_count++;
        $display("wrong value watchdog expected done seen hang");
        test_done();
    end

    initial begin
        rstn_in = 1'b0;
        repeat (10) @(posedge clk_in);
        #1;
        rstn_in = 1'b1;
        for (int i = 0; i < 8; i++) begin
            t_flow(i < 6, i[2:0], i[0]);
        end
        t_ext(1'b1);
        t_ext(1'b0);
        t_timeout();
        test_done();
    end
endmodule : testbench
